// >>> verilog/slot_sched_host.v
/*
 Host-side transaction-group scheduler with an AXI4-Lite register slave.
 Runs control packet, host-transmit slots, bus turn, notification window,
 device-transmit slots and the closing bus turn, in 1 us protocol ticks.
 Assumes link outputs feed radio logic on the same clock.
*/
`default_nettype none
`include "slot_sched_consts.vh"

module slot_sched_host (
  input  wire        clk,
  input  wire        resetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         ctrl_pkt_tx,
  output reg         host_tx,
  output reg         host_rx,
  output reg         slot_start,
  output reg         pkt_start,
  output reg         std_preamble,
  output reg         notify_window,
  output reg  [7:0]  blk_byte,
  output reg         blk_valid,
  input  wire        blk_ready
);

  localparam S_IDLE = 3'h0;
  localparam S_CTRL = 3'h1;
  localparam S_GAP  = 3'h2;
  localparam S_OUT  = 3'h3;
  localparam S_NOTE = 3'h4;
  localparam S_IN   = 3'h5;

  reg [31:0] ctrl_reg;
  reg [15:0] ctrl_len_reg;
  reg [31:0] out_cfg_reg;
  reg [31:0] in_cfg_reg;
  reg [7:0]  notify_reg;
  reg        late_reg;
  reg [15:0] groups_reg;
  reg [15:0] timer_reg;
  reg [5:0]  div_reg;
  reg        tick_reg;
  reg [2:0]  state_reg;
  reg [2:0]  gap_next_reg;
  reg [15:0] cnt_reg;
  reg [7:0]  idx_reg;
  reg [7:0]  pkt_reg;
  reg        pkt_gap_reg;
  reg        win_ok_reg;
  reg [7:0]  win_n_reg;
  reg [15:0] win_start_reg;
  reg        send_reg;
  reg [7:0]  aw_addr_reg;
  reg        aw_got_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        w_got_reg;
  reg [2:0]  state_next;
  reg [2:0]  gap_next;
  reg [15:0] cnt_next;
  reg [7:0]  idx_next;

  wire [7:0]  out_n   = out_cfg_reg[7:0];
  wire [7:0]  burst_n = (out_cfg_reg[15:8] == 8'h00) ? 8'h01
                                                     : out_cfg_reg[15:8];
  wire [15:0] pkt_len = out_cfg_reg[31:16];
  wire [7:0]  in_n    = in_cfg_reg[7:0];
  wire [15:0] in_len  = in_cfg_reg[31:16];
  wire        run     = ctrl_reg[`CTRL_RUN_BIT];
  wire        done    = tick_reg && (cnt_reg == 16'h0001);
  wire [15:0] bgap    = (`BURST_GAP_US > `BURST_GAP_MAX_US) ?
                        `BURST_GAP_MAX_US : `BURST_GAP_US;

  // ********************************************
  // Helpers
  // ********************************************
  function [15:0] atleast1;
    input [15:0] v;
    begin
      atleast1 = (v == 16'h0000) ? 16'h0001 : v;
    end
  endfunction

  function [31:0] win_start;
    input [15:0] cl;
    input [7:0]  on;
    input [7:0]  bu;
    input [15:0] pl;
    input [15:0] bg;
    reg   [31:0] slot;
    begin
      slot = {24'h0, bu} * {16'h0, atleast1(pl)}
           + ({24'h0, bu} - 32'h1) * {16'h0, bg};
      win_start = {16'h0, atleast1(cl)} + {16'h0, `TURN_GAP_US};
      if (on != 8'h00) begin
        win_start = win_start + {24'h0, on} * slot
                  + {24'h0, on} * {16'h0, `STD_GAP_US};
      end
    end
  endfunction

  wire [31:0] ws_calc = win_start(ctrl_len_reg, out_n, burst_n,
                                  pkt_len, bgap);

  // ********************************************
  // Protocol tick divider
  // ********************************************
  always @(posedge clk) begin
    if (!resetn) begin
      div_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end else if (div_reg == `TICK_CYCLES - 1) begin
      div_reg  <= 6'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 6'h01;
      tick_reg <= 1'b0;
    end
  end

  // ********************************************
  // Slot sequencer
  // ********************************************
  always @* begin
    state_next = state_reg;
    gap_next   = gap_next_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    case (state_reg)
      S_IDLE: begin
        if (run && tick_reg) begin
          state_next = S_CTRL;
          cnt_next   = atleast1(ctrl_len_reg);
        end
      end
      S_CTRL: begin
        if (done) begin
          state_next = S_GAP;
          idx_next   = 8'h00;
          if (out_n != 8'h00) begin
            gap_next = S_OUT;
            cnt_next = `STD_GAP_US;
          end else if (win_ok_reg || in_n != 8'h00) begin
            gap_next = win_ok_reg ? S_NOTE : S_IN;
            cnt_next = `TURN_GAP_US;
          end else begin
            gap_next = S_CTRL;
            cnt_next = `TURN_GAP_US;
          end
        end
      end
      S_OUT: begin
        if (done && pkt_gap_reg == 1'b0 && pkt_reg == burst_n - 8'h01) begin
          state_next = S_GAP;
          idx_next   = idx_reg + 8'h01;
          if (idx_reg != out_n - 8'h01) begin
            gap_next = S_OUT;
            cnt_next = `STD_GAP_US;
          end else if (win_ok_reg || in_n != 8'h00) begin
            gap_next = win_ok_reg ? S_NOTE : S_IN;
            idx_next = 8'h00;
            cnt_next = `TURN_GAP_US;
          end else begin
            gap_next = S_CTRL;
            cnt_next = `STD_GAP_US;
          end
        end
      end
      S_NOTE: begin
        if (done) begin
          cnt_next = `MSG_SLOT_US;
          idx_next = idx_reg + 8'h01;
          if (idx_reg == win_n_reg - 8'h01) begin
            state_next = S_GAP;
            idx_next   = 8'h00;
            gap_next   = (in_n != 8'h00) ? S_IN : S_CTRL;
            cnt_next   = (in_n != 8'h00) ? `IN_GAP_US
                                         : `TURN_GAP_US;
          end
        end
      end
      S_IN: begin
        if (done) begin
          state_next = S_GAP;
          idx_next   = idx_reg + 8'h01;
          gap_next   = (idx_reg != in_n - 8'h01) ? S_IN : S_CTRL;
          cnt_next   = (idx_reg != in_n - 8'h01) ? `IN_GAP_US
                                                 : `TURN_GAP_US;
        end
      end
      S_GAP: begin
        if (done) begin
          state_next = gap_next_reg;
          case (gap_next_reg)
            S_OUT:   cnt_next = atleast1(pkt_len);
            S_NOTE:  cnt_next = `MSG_SLOT_US;
            S_IN:    cnt_next = atleast1(in_len);
            default: cnt_next = atleast1(ctrl_len_reg);
          endcase
          if (gap_next_reg == S_CTRL && !run) begin
            state_next = S_IDLE;
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
    if (tick_reg && !done && state_reg != S_IDLE) begin
      cnt_next = cnt_reg - 16'h0001;
    end
    if (state_reg == S_OUT && done && !(pkt_gap_reg == 1'b0 &&
        pkt_reg == burst_n - 8'h01)) begin
      cnt_next = pkt_gap_reg ? atleast1(pkt_len) : atleast1(bgap);
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      state_reg     <= S_IDLE;
      gap_next_reg  <= S_IDLE;
      cnt_reg       <= 16'h0001;
      idx_reg       <= 8'h00;
      pkt_reg       <= 8'h00;
      pkt_gap_reg   <= 1'b0;
      timer_reg     <= 16'h0000;
      win_ok_reg    <= 1'b0;
      win_n_reg     <= 8'h00;
      win_start_reg <= 16'h0000;
      send_reg      <= 1'b0;
      late_reg      <= 1'b0;
      groups_reg    <= 16'h0000;
      ctrl_pkt_tx   <= 1'b0;
      host_tx       <= 1'b0;
      host_rx       <= 1'b0;
      slot_start    <= 1'b0;
      pkt_start     <= 1'b0;
      std_preamble  <= 1'b0;
      notify_window <= 1'b0;
    end else begin
      state_reg    <= state_next;
      gap_next_reg <= gap_next;
      cnt_reg      <= cnt_next;
      idx_reg      <= idx_next;
      send_reg     <= 1'b0;
      if (state_next == S_CTRL && state_reg != S_CTRL) begin
        timer_reg  <= 16'h0000;
        groups_reg <= groups_reg + 16'h0001;
        // Window allowed only when offered and early enough
        win_ok_reg <= (notify_reg != 8'h00) &&
                      (ws_calc <= `WINDOW_MAX_US);
        win_start_reg <= ws_calc[15:0];
        // Count frozen per group so a mid-group write cannot stretch it
        win_n_reg     <= notify_reg;
        send_reg <= (notify_reg != 8'h00) &&
                    (ws_calc <= `WINDOW_MAX_US);
        if (notify_reg != 8'h00 && ws_calc > `WINDOW_MAX_US) begin
          late_reg <= 1'b1;
        end
      end else if (tick_reg) begin
        timer_reg <= timer_reg + 16'h0001;
      end
      if (state_reg == S_OUT && done) begin
        pkt_gap_reg <= ~pkt_gap_reg;
        if (pkt_gap_reg) begin
          pkt_reg <= pkt_reg + 8'h01;
        end
      end
      if (state_next != S_OUT) begin
        pkt_reg     <= 8'h00;
        pkt_gap_reg <= 1'b0;
      end
      // Software clear loses to a fresh late event
      if (aw_got_reg && w_got_reg && !s_axi_bvalid &&
          aw_addr_reg == `REG_STATUS && w_strb_reg[0] &&
          w_data_reg[`STAT_LATE_BIT] &&
          !(send_reg == 1'b0 && state_next == S_CTRL &&
            state_reg != S_CTRL && notify_reg != 8'h00 &&
            ws_calc > `WINDOW_MAX_US)) begin
        late_reg <= 1'b0;
      end
      ctrl_pkt_tx <= (state_next == S_CTRL);
      host_tx     <= (state_next == S_CTRL) ||
                     (state_next == S_OUT && !(pkt_gap_reg ^
                      (state_reg == S_OUT && done)));
      // Listen one guard time ahead of device slots
      host_rx <= (state_next == S_NOTE) || (state_next == S_IN) ||
                 (state_next == S_GAP && cnt_next <= `GUARD_US &&
                  (gap_next == S_NOTE || gap_next == S_IN));
      slot_start <= (state_next != state_reg) &&
                    (state_next == S_OUT || state_next == S_IN ||
                     state_next == S_NOTE);
      pkt_start  <= (state_next == S_OUT) && ((state_reg != S_OUT) ||
                    (done && pkt_gap_reg));
      // Streaming preamble is optional; first packet never uses it
      std_preamble <= (state_next == S_CTRL && state_reg != S_CTRL) ||
                      (state_next != state_reg && state_next == S_OUT) ||
                      (state_next == S_OUT && done && pkt_gap_reg &&
                       ctrl_reg[`CTRL_STDPRE_BIT]);
      notify_window <= (state_next == S_NOTE);
    end
  end

  wire [7:0] blk_byte_w;
  wire       blk_valid_w;

  notify_block_builder builder (
    .clk                (clk),
    .resetn             (resetn),
    .send               (send_reg),
    .slot_start_time    (win_start_reg),
    .message_slot_count (win_n_reg),
    .blk_ready          (blk_ready),
    .blk_byte           (blk_byte_w),
    .blk_valid          (blk_valid_w)
  );

  always @*
    {blk_byte, blk_valid} = {blk_byte_w, blk_valid_w};

  // ********************************************
  // AXI4-Lite slave
  // ********************************************
  always @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg      <= `CTRL_RESET;
      ctrl_len_reg  <= `CTRL_LEN_RESET;
      out_cfg_reg   <= 32'h0000_0000;
      in_cfg_reg    <= 32'h0000_0000;
      notify_reg    <= 8'h00;
      aw_addr_reg   <= 8'h00;
      aw_got_reg    <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      w_got_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_got_reg  <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_got_reg  <= 1'b1;
      end
      if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_reg)
          `REG_CTRL:     ctrl_reg     <= w_data_reg;
          `REG_CTRL_LEN: ctrl_len_reg <= w_data_reg[15:0];
          `REG_OUT_CFG:  out_cfg_reg  <= w_data_reg;
          `REG_IN_CFG:   in_cfg_reg   <= w_data_reg;
          `REG_NOTIFY:   notify_reg   <= w_data_reg[7:0];
          `REG_STATUS:   s_axi_bresp  <= `RESP_OKAY;
          default:       s_axi_bresp  <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL:     s_axi_rdata <= ctrl_reg;
          `REG_CTRL_LEN: s_axi_rdata <= {16'h0000, ctrl_len_reg};
          `REG_OUT_CFG:  s_axi_rdata <= out_cfg_reg;
          `REG_IN_CFG:   s_axi_rdata <= in_cfg_reg;
          `REG_NOTIFY:   s_axi_rdata <= {24'h000000, notify_reg};
          `REG_STATUS:   s_axi_rdata <= {groups_reg, 14'h0000, late_reg,
                                         (state_reg != S_IDLE)};
          `REG_TIMER:    s_axi_rdata <= {16'h0000, timer_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // slot_sched_host
`default_nettype wire

// >>> verilog/slot_sched_consts.vh
/*
 Constants of the transaction-group scheduler: own register offsets,
 field positions, reset values and slot timing in microseconds.
 Assumes a 50 MHz clock and a 1 us protocol tick.
*/
`ifndef SLOT_SCHED_CONSTS_VH
`define SLOT_SCHED_CONSTS_VH

// ********************************************
// Register offsets (byte addresses)
// ********************************************
`define REG_CTRL        8'h00
`define REG_CTRL_LEN    8'h04
`define REG_OUT_CFG     8'h08
`define REG_IN_CFG      8'h0c
`define REG_NOTIFY      8'h10
`define REG_STATUS      8'h14
`define REG_TIMER       8'h18

// ********************************************
// Fields and reset values
// ********************************************
`define CTRL_RUN_BIT    0
`define CTRL_STDPRE_BIT 1
`define STAT_BUSY_BIT   0
`define STAT_LATE_BIT   1
`define CTRL_RESET      32'h0000_0000
`define CTRL_LEN_RESET  16'h0020
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Notification allocation block: byte 0 type field and block length in bytes
`define BLK_TYPE_LSB    6
`define BLK_TYPE_CODE   2'h2
`define BLK_BYTES       3'h4

// ********************************************
// Timing
// ********************************************
`define CLK_NS          20
`define TICK_NS         1000
`define TICK_CYCLES     (`TICK_NS / `CLK_NS)
`define STD_GAP_US      16'h000a
`define GUARD_US        16'h0004
`define BUSTURN_US      16'h0006
`define TURN_GAP_US     (`GUARD_US + `BUSTURN_US)
`define IN_GAP_US       (`STD_GAP_US + `GUARD_US)
`define NOTIF_MAX_US    16'h0028
`define MIN_INTERFRAME_SPACE_US         16'h0002
`define MSG_SLOT_US     (`NOTIF_MAX_US + `MIN_INTERFRAME_SPACE_US + `GUARD_US)
`define BURST_GAP_US    16'h0001
`define BURST_GAP_MAX_US 16'h0002
`define WINDOW_MAX_US   32'd25000

`endif

// >>> verilog/notify_block_builder.v
/*
 Serialises the four-byte notification allocation block.
 Assumes the consumer takes a byte when blk_valid and blk_ready are high.
*/
`default_nettype none
`include "slot_sched_consts.vh"

module notify_block_builder (
  input  wire        clk,
  input  wire        resetn,
  input  wire        send,
  input  wire [15:0] slot_start_time,
  input  wire [7:0]  message_slot_count,
  input  wire        blk_ready,
  output reg  [7:0]  blk_byte,
  output reg         blk_valid
);

  reg [2:0]  idx_reg;
  reg [15:0] start_reg;
  reg [7:0]  count_reg;

  // ********************************************
  // Byte selection
  // ********************************************
  function [7:0] pick;
    input [2:0]  i;
    input [15:0] st;
    input [7:0]  n;
    begin
      case (i)
        3'h0: pick = {`BLK_TYPE_CODE, 6'h00};
        3'h1: pick = st[7:0];
        3'h2: pick = st[15:8];
        3'h3: pick = n;
        default: pick = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (!resetn) begin
      idx_reg   <= 3'h0;
      start_reg <= 16'h0000;
      count_reg <= 8'h00;
      blk_byte  <= 8'h00;
      blk_valid <= 1'b0;
    end else if (!blk_valid) begin
      // One block per send; a send while busy is dropped
      if (send) begin
        start_reg <= slot_start_time;
        count_reg <= message_slot_count;
        idx_reg   <= 3'h1;
        blk_byte  <= pick(3'h0, slot_start_time, message_slot_count);
        blk_valid <= 1'b1;
      end
    end else if (blk_ready) begin
      if (idx_reg == `BLK_BYTES) begin
        blk_valid <= 1'b0;
      end else begin
        blk_byte <= pick(idx_reg, start_reg, count_reg);
        idx_reg  <= idx_reg + 3'h1;
      end
    end
  end

endmodule // notify_block_builder
`default_nettype wire

// >>> dv/slot_sched_host_properties.sv
/* Checker on the scheduler's link and block ports.
   Assumes binding to slot_sched_host and slot_sched_consts.vh. */
`default_nettype none
`include "slot_sched_consts.vh"
module slot_sched_host_properties (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ctrl_pkt_tx,
  input wire logic       host_tx,
  input wire logic       host_rx,
  input wire logic       slot_start,
  input wire logic       pkt_start,
  input wire logic       std_preamble,
  input wire logic       notify_window,
  input wire logic [7:0] blk_byte,
  input wire logic       blk_valid,
  input wire logic       blk_ready
);
  // Gaps may come one tick short at phase entry
  localparam int T = `TICK_CYCLES;
  localparam int STD_MIN = (`STD_GAP_US - 1) * T;
  localparam int TURN_MIN = (`TURN_GAP_US - 1) * T;
  localparam int RX_MIN = (`BUSTURN_US - 1) * T;
  localparam int BURST_MAX = (`BURST_GAP_MAX_US + 1) * T;
  logic [15:0] tx_low;
  logic [15:0] rx_low;
  logic [1:0]  bidx;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Idle counters and block byte index
  // ****************************************
  always @(posedge clk) begin
    if (!resetn) begin
      tx_low <= 16'hffff;
      rx_low <= 16'hffff;
      bidx <= 2'h0;
    end else begin
      tx_low <= host_tx ? 16'h0000 : tx_low + {15'h0, tx_low != 16'hffff};
      rx_low <= host_rx ? 16'h0000 : rx_low + {15'h0, rx_low != 16'hffff};
      if (blk_valid && blk_ready) bidx <= bidx + 2'h1;
    end
  end
  a_ctrl_pre: assert property (
    $rose(ctrl_pkt_tx) |-> std_preamble) else $error("ctrl preamble");
  a_slot_pre: assert property (
    slot_start && pkt_start |-> std_preamble) else $error("slot preamble");
  a_out_gap: assert property (
    slot_start && pkt_start |-> tx_low >= STD_MIN) else $error("out gap");
  a_burst_gap: assert property (
    pkt_start && !slot_start |-> tx_low <= BURST_MAX) else $error("burst");
  a_rx_turn: assert property (
    $rose(host_rx) |-> tx_low >= RX_MIN) else $error("turn before rx");
  a_ctrl_turn: assert property (
    $rose(ctrl_pkt_tx) |-> rx_low >= TURN_MIN) else $error("turn to ctrl");
  a_win_dir: assert property (
    notify_window |-> host_rx && !host_tx) else $error("window direction");
  a_blk_type: assert property (
    blk_valid && bidx == 2'h0 |-> blk_byte == {`BLK_TYPE_CODE, 6'h00})
    else $error("block byte zero");
  a_blk_hold: assert property (
    blk_valid && !blk_ready |=> blk_valid && $stable(blk_byte))
    else $error("block byte dropped");
  c_window: cover property ($rose(notify_window));
  c_burst: cover property (pkt_start && !slot_start);
  c_stall: cover property (blk_valid && !blk_ready);
endmodule // slot_sched_host_properties

bind slot_sched_host slot_sched_host_properties u_slot_sched_host_properties (
  .clk(clk), .resetn(resetn), .ctrl_pkt_tx(ctrl_pkt_tx),
  .host_tx(host_tx), .host_rx(host_rx), .slot_start(slot_start),
  .pkt_start(pkt_start), .std_preamble(std_preamble),
  .notify_window(notify_window), .blk_byte(blk_byte),
  .blk_valid(blk_valid), .blk_ready(blk_ready));
`default_nettype wire

// >>> dv/device_model.sv
/* Device model: takes notification blocks and times the window.
   Assumes the scheduler's clock and synchronous active-low reset. */
`default_nettype none
`include "slot_sched_consts.vh"
module device_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        stall,
  input  wire logic        ctrl_pkt_tx,
  input  wire logic        notify_window,
  input  wire logic [7:0]  blk_byte,
  input  wire logic        blk_valid,
  output var  logic        blk_ready,
  output var  logic [7:0]  b0,
  output var  logic [7:0]  cnt,
  output var  logic [15:0] start,
  output var  logic [31:0] win_at,
  output var  logic [31:0] win_len,
  output var  logic [15:0] blocks,
  output var  logic [15:0] ctrls,
  output var  logic [15:0] wins,
  output var  logic        dup,
  output var  logic        dev_tx
);
  logic [31:0] cyc;
  logic [7:0]  lfsr;
  logic [7:0]  pick;
  logic [1:0]  idx;
  logic        ctrl_d;
  logic        win_d;
  logic        got;
  logic        dev_rx;
  // Receiver on whenever not sending
  assign dev_rx = !dev_tx;
  always @(posedge clk) begin
    if (!resetn) begin
      {blk_ready, ctrl_d, win_d, got, dup, dev_tx, idx} <= '0;
      {b0, cnt, start, win_at, win_len, blocks, ctrls, wins} <= '0;
      {cyc, pick} <= '0;
      lfsr <= 8'h5a;
    end else begin
      ctrl_d <= ctrl_pkt_tx;
      win_d <= notify_window;
      blk_ready <= !(stall && blk_ready);
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      cyc <= cyc + 32'h1;
      if (ctrl_pkt_tx && !ctrl_d) begin
        cyc <= 32'h1;
        ctrls <= ctrls + 16'h1;
        got <= 1'b0;
      end
      if (blk_valid && blk_ready) begin
        idx <= idx + 2'h1;
        case (idx)
          2'h0: b0 <= blk_byte;
          2'h1: start[7:0] <= blk_byte;
          2'h2: start[15:8] <= blk_byte;
          default: begin
            cnt <= blk_byte;
            blocks <= blocks + 16'h1;
            dup <= dup | got;
            got <= 1'b1;
            pick <= (blk_byte == 8'h00) ? 8'h00 : lfsr % blk_byte;
          end
        endcase
      end
      if (notify_window && !win_d) begin
        win_at <= cyc;
        wins <= wins + 16'h1;
      end
      if (!notify_window && win_d) win_len <= cyc - win_at;
      // One start per window, none when no slots offered
      dev_tx <= notify_window && win_d && cnt != 8'h00 &&
        cyc - win_at == 32'(pick) * `MSG_SLOT_US * `TICK_CYCLES + 1;
    end
  end
endmodule // device_model
`default_nettype wire

// >>> dv/slot_sched_host_tb_top.sv
/* Bench for slot_sched_host over AXI4-Lite with a device model.
   Assumes checker bound by its own file. */
`default_nettype none
`include "slot_sched_consts.vh"
module slot_sched_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, stall, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready, blk_ready, blk_valid;
  logic ctrl_pkt_tx, host_tx, host_rx, slot_start, pkt_start, dev_tx;
  logic std_preamble, notify_window, dup;
  logic [7:0]  awaddr, araddr, blk_byte, b0, cnt;
  logic [31:0] wdata, rdata, d, win_at, win_len;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] start, blocks, ctrls, wins, snap_b, snap_w;
  int err_count = 0;
  int checks_done = 0;
  slot_sched_host u_slot_sched_host (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctrl_pkt_tx(ctrl_pkt_tx),
    .host_tx(host_tx), .host_rx(host_rx), .slot_start(slot_start),
    .pkt_start(pkt_start), .std_preamble(std_preamble),
    .notify_window(notify_window), .blk_byte(blk_byte),
    .blk_valid(blk_valid), .blk_ready(blk_ready));
  device_model u_device_model (.clk(clk), .resetn(resetn), .stall(stall),
    .ctrl_pkt_tx(ctrl_pkt_tx), .notify_window(notify_window),
    .blk_byte(blk_byte), .blk_valid(blk_valid), .blk_ready(blk_ready),
    .b0(b0), .cnt(cnt), .start(start), .win_at(win_at), .win_len(win_len),
    .blocks(blocks), .ctrls(ctrls), .wins(wins), .dup(dup), .dev_tx(dev_tx));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_up;
    check(32'h0, 32'h1);
    end_of_test();
  endtask
  function automatic logic [31:0] near(input logic [31:0] a, b);
    near = {31'h0, (a > b ? a - b : b - a) <= 32'h1};
  endfunction
  // Write: both channels offered together, bready held until bvalid
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 1000) give_up();
    check(32'(bresp), 32'(a >= `REG_TIMER ? `RESP_SLVERR : `RESP_OKAY));
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task axi_rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 1000) give_up();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait for k more control packet starts
  task wait_ctrl(input int k);
    int i, t;
    t = ctrls + k;
    for (i = 0; i < 40000 && ctrls < t; i++) @(posedge clk);
    if (ctrls < t) give_up();
    repeat (20) @(posedge clk);
  endtask
  task do_reset;
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {resetn, stall, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    do_reset();
    axi_rd(`REG_CTRL);
    check(d, `CTRL_RESET);
    axi_rd(`REG_CTRL_LEN);
    check(d, 32'(`CTRL_LEN_RESET));
    axi_rd(8'h1c);
    check({d[29:0], r}, 32'(`RESP_SLVERR));
    axi_wr(8'h1c, 32'h0000_0001);
    $display("register test done");
    stall <= 1'b1;
    axi_wr(`REG_OUT_CFG, 32'h0005_0202);
    axi_wr(`REG_IN_CFG, 32'h0005_0001);
    axi_wr(`REG_NOTIFY, 32'h0000_0003);
    axi_wr(`REG_CTRL, 32'h0000_0001);
    wait_ctrl(3);
    check(32'(blocks >= 16'h2), 32'h1);
    check(32'(dup), 32'h0);
    check(32'(b0), {24'h0, `BLK_TYPE_CODE, 6'h00});
    check(32'(cnt), 32'h3);
    check(near(32'(start), win_at / `TICK_CYCLES), 32'h1);
    check(near(win_len / `TICK_CYCLES, 32'h3 * `MSG_SLOT_US), 32'h1);
    axi_rd(`REG_STATUS);
    check({d[31:16] >= 16'h2, d[0]}, 32'h3);
    $display("window test done");
    axi_wr(`REG_NOTIFY, 32'h0000_0000);
    wait_ctrl(1);
    {snap_b, snap_w} = {blocks, wins};
    wait_ctrl(2);
    check({blocks, wins}, {snap_b, snap_w});
    $display("empty window test done");
    do_reset();
    stall <= 1'b0;
    axi_wr(`REG_OUT_CFG, 32'hffff_0101);
    axi_wr(`REG_NOTIFY, 32'h0000_0002);
    axi_wr(`REG_CTRL, 32'h0000_0001);
    wait_ctrl(1);
    axi_rd(`REG_STATUS);
    check({d[1], blocks}, 32'h1_0000);
    axi_wr(`REG_STATUS, 32'h0000_0002);
    axi_rd(`REG_STATUS);
    check(32'(d[1]), 32'h0);
    $display("late window test done");
    end_of_test();
  end
endmodule // slot_sched_host_tb_top
`default_nettype wire
